// ==== core/pio_port_defines.vh ====
// Constants shared by the parallel I/O port files
`ifndef PIO_PORT_DEFINES_VH
`define PIO_PORT_DEFINES_VH

// ==========================================================
// Port geometry
`define PIO_WIDTH          8
`define PIO_SEL_W          3

// ==========================================================
// Register select codes, shared by write and read except PIO_SEL_READBACK, which is read only
`define PIO_SEL_READBACK   3'h0
`define PIO_SEL_LATCH      3'h1
`define PIO_SEL_DIR        3'h2
`define PIO_SEL_ALT        3'h3
`define PIO_SEL_DRIVE      3'h4
`define PIO_SEL_PULLUP     3'h5

// ==========================================================
// Field values
`define PIO_DIR_INPUT      1'h0
`define PIO_DIR_OUTPUT     1'h1
`define PIO_DRV_PUSHPULL   1'h0
`define PIO_DRV_OPENDRAIN  1'h1

// ==========================================================
// Reset values
`define PIO_RST_LATCH      8'h00
`define PIO_RST_DIR        8'h00
`define PIO_RST_ALT        8'h00
`define PIO_RST_DRIVE      8'h00
`define PIO_RST_PULLUP     8'h00
`define PIO_RST_READBACK   8'h00
`define PIO_RST_RESERVED   8'h00

`endif

// ==== core/pio_sync.v ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
`include "pio_port_defines.vh"

module pio_sync #(
  parameter WIDTH = `PIO_WIDTH
) (
  input  wire             i_mclk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;

  // ==========================================================
  // First stage feeds only the second stage
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync   <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== core/pio_port.v ====
// Parallel I/O port: output latch, pin sampling, per-pin pad control
`timescale 1ns/100ps
`default_nettype none
`include "pio_port_defines.vh"

module pio_port #(
  parameter               WIDTH         = `PIO_WIDTH,
  parameter [WIDTH-1:0]   RESERVED_MASK = `PIO_RST_RESERVED
) (
  input  wire                  i_mclk,
  input  wire                  i_rst_n,
  input  wire                  i_wr_stb,
  input  wire [`PIO_SEL_W-1:0] i_wr_sel,
  input  wire [WIDTH-1:0]      i_wr_data,
  input  wire                  i_rd_stb,
  input  wire [`PIO_SEL_W-1:0] i_rd_sel,
  output reg  [WIDTH-1:0]      o_rd_data,
  output reg                   o_rd_valid,
  input  wire [WIDTH-1:0]      i_alt_out,
  input  wire [WIDTH-1:0]      i_pin_in,
  output wire [WIDTH-1:0]      o_pin_out,
  output wire [WIDTH-1:0]      o_pin_oe,
  output wire [WIDTH-1:0]      o_pullup_en,
  output wire [WIDTH-1:0]      o_pin_level
);

  reg  [WIDTH-1:0] port_output_latch_reg;
  reg  [WIDTH-1:0] port_direction_select_reg;
  reg  [WIDTH-1:0] alt_function_output_enable_reg;
  reg  [WIDTH-1:0] output_drive_type_select_reg;
  reg  [WIDTH-1:0] pullup_connect_select_reg;
  reg  [WIDTH-1:0] rd_data_next;
  wire [WIDTH-1:0] pin_sync;

  // ==========================================================
  // Pin level synchroniser
  pio_sync #(
    .WIDTH   (WIDTH)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (i_pin_in),
    .o_sync  (pin_sync)
  );

  assign o_pin_level = pin_sync;

  // ==========================================================
  // Configuration and latch writes in the core's write cycle
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_output_latch_reg          <= `PIO_RST_LATCH;
      port_direction_select_reg      <= `PIO_RST_DIR;
      alt_function_output_enable_reg <= `PIO_RST_ALT;
      output_drive_type_select_reg   <= `PIO_RST_DRIVE;
      pullup_connect_select_reg      <= `PIO_RST_PULLUP;
    end else if (i_wr_stb) begin
      case (i_wr_sel)
        `PIO_SEL_LATCH: begin
          port_output_latch_reg <= i_wr_data;
        end
        `PIO_SEL_DIR: begin
          port_direction_select_reg <= i_wr_data;
        end
        `PIO_SEL_ALT: begin
          alt_function_output_enable_reg <= i_wr_data;
        end
        `PIO_SEL_DRIVE: begin
          output_drive_type_select_reg <= i_wr_data;
        end
        `PIO_SEL_PULLUP: begin
          pullup_connect_select_reg <= i_wr_data;
        end
        default: begin
          port_output_latch_reg <= port_output_latch_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data path
  always @* begin
    rd_data_next = {WIDTH{1'b0}};
    case (i_rd_sel)
      `PIO_SEL_READBACK: begin
        rd_data_next = pin_sync;
      end
      `PIO_SEL_LATCH: begin
        rd_data_next = port_output_latch_reg;
      end
      `PIO_SEL_DIR: begin
        rd_data_next = port_direction_select_reg;
      end
      `PIO_SEL_ALT: begin
        rd_data_next = alt_function_output_enable_reg;
      end
      `PIO_SEL_DRIVE: begin
        rd_data_next = output_drive_type_select_reg;
      end
      `PIO_SEL_PULLUP: begin
        rd_data_next = pullup_connect_select_reg;
      end
      default: begin
        rd_data_next = {WIDTH{1'b0}};
      end
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data  <= {WIDTH{1'b0}};
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        o_rd_data <= rd_data_next;
      end
    end
  end

  // ==========================================================
  // Per-pin pad control
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      wire is_out;
      wire is_od;
      wire drive_val;
      // Oscillator pins never driven by the port
      assign is_out = (port_direction_select_reg[g] == `PIO_DIR_OUTPUT) & ~RESERVED_MASK[g];
      assign is_od  = (output_drive_type_select_reg[g] == `PIO_DRV_OPENDRAIN);
      assign drive_val = alt_function_output_enable_reg[g] ? i_alt_out[g]
                                                           : port_output_latch_reg[g];
      // Open drain drives low only
      assign o_pin_out[g]   = is_od ? 1'b0 : drive_val;
      assign o_pin_oe[g]    = is_out & (~is_od | ~drive_val);
      assign o_pullup_en[g] = pullup_connect_select_reg[g] & ~RESERVED_MASK[g] & (~is_out | is_od);
    end
  endgenerate

endmodule
`default_nettype wire

// ==== test/pio_port_checker.sv ====
// Concurrent checks on the port's top-level pins
`timescale 1ns/100ps
`default_nettype none
module pio_port_checker (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_wr_stb,
  input wire logic [2:0] i_wr_sel,
  input wire logic [7:0] i_wr_data,
  input wire logic       i_rd_stb,
  input wire logic [2:0] i_rd_sel,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic [7:0] i_pin_in,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe,
  input wire logic [7:0] o_pullup_en,
  input wire logic [7:0] o_pin_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_pin; i_rd_stb && i_rd_sel == 3'h0; endsequence
  sequence s_wr(s); i_wr_stb && i_wr_sel == s; endsequence
  chk_rd_valid: assert property (i_rd_stb |=> o_rd_valid) else $error("rd valid late");
  chk_no_stray: assert property (!i_rd_stb |=> !o_rd_valid) else $error("stray rd valid");
  chk_rd_hold: assert property (!i_rd_stb |=> $stable(o_rd_data)) else $error("rd data moved");
  chk_pin_sync: assert property ($past(i_rst_n, 2) && $past(i_rst_n) |->
    o_pin_level == $past(i_pin_in, 2)) else $error("pin level lag");
  chk_rd_back: assert property (s_rd_pin |=> o_rd_data == $past(o_pin_level)) else $error("readback");
  chk_dir_gate: assert property (s_wr(3'h2) |=> (o_pin_oe & ~$past(i_wr_data)) == 8'h00)
    else $error("input pin driven");
  chk_od_low: assert property (s_wr(3'h4) |=> (o_pin_out & $past(i_wr_data)) == 8'h00)
    else $error("open drain high");
  chk_pullup_gate: assert property ((o_pullup_en & o_pin_oe & o_pin_out) == 8'h00) else $error("pullup");
  chk_rst_inputs: assert property ($rose(i_rst_n) |-> (o_pin_oe | o_pullup_en) == 8'h00)
    else $error("not input after reset");
endmodule
`default_nettype wire

// ==== test/pio_pad_model.sv ====
// Board side of the pads: wire level, pull-ups, oscillator pins
`timescale 1ns/100ps
`default_nettype none
module pio_pad_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pu,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output wire logic [7:0] o_pin
);
  logic       flt = 1'b0;
  wire  [7:0] w;
  always @(posedge i_mclk) flt <= ~flt;
  // Unpulled, undriven pins wander
  assign w = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pu | {8{flt}}));
  assign o_pin = {w[7:2], flt, ~flt};
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the parallel I/O port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       i_mclk = 1'b0, i_rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [2:0] wr_sel = 3'h0, rd_sel = 3'h0;
  logic [7:0] wr_data = 8'h00, alt = 8'h00, ext = 8'h00, ext_en = 8'h00;
  wire  [7:0] rd_data, out, oe, pu, lvl, pin;
  wire        rd_valid;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  always #50 i_mclk = ~i_mclk;
  pio_port #(.WIDTH(8), .RESERVED_MASK(8'h03)) DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_stb(wr_stb),
    .i_wr_sel(wr_sel), .i_wr_data(wr_data), .i_rd_stb(rd_stb), .i_rd_sel(rd_sel), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_alt_out(alt), .i_pin_in(pin), .o_pin_out(out), .o_pin_oe(oe),
    .o_pullup_en(pu), .o_pin_level(lvl));
  pio_pad_model u_pad (.i_mclk(i_mclk), .i_out(out), .i_oe(oe), .i_pu(pu), .i_ext(ext), .i_ext_en(ext_en),
    .o_pin(pin));
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge i_mclk);
    wr_stb = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(negedge i_mclk);
    wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] e, input logic [7:0] m);
    @(negedge i_mclk);
    rd_stb = 1'b1;
    rd_sel = s;
    @(negedge i_mclk);
    rd_stb = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rd_data", e & m, rd_data & m);
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge i_mclk);
    i_rst_n = 1'b1;
    rd(3'h2, 8'h00, 8'hff);
    rd(3'h3, 8'h00, 8'hff);
    wr(3'h2, 8'hff);
    wr(3'h1, 8'ha5);
    chk("oe", 8'hfc, oe);
    chk("out", 8'ha5, out);
    wr(3'h4, 8'h0f);
    chk("oe", 8'hf8, oe);
    chk("out", 8'ha0, out);
    wr(3'h5, 8'hff);
    chk("pu", 8'h0c, pu);
    wr(3'h6, 8'h00);
    rd(3'h6, 8'h00, 8'hff);
    rd(3'h1, 8'ha5, 8'hff);
    wr(3'h2, 8'h0f);
    ext = 8'h30;
    ext_en = 8'hf0;
    repeat (2) @(negedge i_mclk);
    chk("lvl", 8'h34, lvl & 8'hfc);
    rd(3'h0, 8'h34, 8'hfc);
    alt = 8'h3c;
    wr(3'h4, 8'h00);
    wr(3'h2, 8'hff);
    wr(3'h3, 8'hff);
    chk("out", 8'h3c, out);
    i_rst_n = 1'b0;
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    chk("oe", 8'h00, oe);
    rd(3'h3, 8'h00, 8'hff);
    final_report();
  end
endmodule
bind pio_port pio_port_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_stb(i_wr_stb),
  .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_pullup_en(o_pullup_en), .o_pin_level(o_pin_level));
`default_nettype wire
